// file: verilog/tpe_consts.svh
/*
 constants of the pwm / single pulse / encoder timer block: register offsets,
 field positions, reset values. assumes a 16-bit counter and byte addresses.
*/
// Behaviour
// - down-count pwm1: low while counter exceeds compare
// - down-count pwm1 compare above reload keeps reference high
// - direction bit high counts down, low up
// - any nonzero center select gives center counting
// - center select 01/10/11 flags down/up/both matches
// - hardware owns direction bit in center mode
// - center start uses held direction, no joint writes
// - counter write 0/reload sets direction in center mode, no update
// - single pulse clears enable on update event
// - trigger edge in trigger mode sets enable
// - pwm2 single pulse rises at match, falls at reload
// - fast enable forces match level on trigger
// - fast enable acts only in pwm modes
// - slave select 001/010/011 picks encoder edges
// - encoder edges step counter when enabled
// - input one edges count per table
// - input two edges count per table
// - direction recomputed on every encoder transition of one input alone
// - encoder counter wraps between zero and reload
// - xor select feeds pins two to four
// - compare mode 110 pwm1, 111 pwm2
// - up-count pwm1 high below compare, pwm2 inverse
`ifndef TPE_CONSTS_SVH
`define TPE_CONSTS_SVH
// ****************************************************
// register offsets
// ****************************************************
`define A_CTRL 8'h00
`define A_SLAVE 8'h04
`define A_CHAN 8'h08
`define A_RELOAD 8'h0c
`define A_COMPARE 8'h10
`define A_COUNT 8'h14
`define A_STATUS 8'h18
// ****************************************************
// field positions
// ****************************************************
`define F_EN 0
`define F_OPM 1
`define F_DIR 2
`define F_CMS_LO 3
`define F_CMS_HI 4
`define F_XOR 5
`define F_SMS_LO 0
`define F_SMS_HI 2
`define F_TSEL 3
`define F_POL1 4
`define F_POL2 5
`define F_OCM_LO 0
`define F_OCM_HI 2
`define F_FE 3
`define F_OPOL 4
`define F_CFLAG 0
`define F_UFLAG 1
`define F_REF 2
// ****************************************************
// values
// ****************************************************
`define CMS_EDGE 2'h0
`define CMS_DOWN 2'h1
`define CMS_UP 2'h2
`define CMS_BOTH 2'h3
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define WORD_ZERO 32'h0000_0000
`endif

// file: verilog/tpe_pkg.sv
/*
 types of the pwm / single pulse / encoder timer block.
 assumes tpe_consts.svh for the numeric constants.
*/
package tpe_pkg;
   typedef logic [31:0] word_t;
   typedef logic [15:0] cnt_t;
   typedef logic [7:0] addr_t;
   typedef enum logic [2:0]
   {
      OCM_FROZEN = 3'h0,
      OCM_SET = 3'h1,
      OCM_CLEAR = 3'h2,
      OCM_TOGGLE = 3'h3,
      OCM_LOW = 3'h4,
      OCM_HIGH = 3'h5,
      OCM_PWM1 = 3'h6,
      OCM_PWM2 = 3'h7
   } ocm_e;
   typedef enum logic [2:0]
   {
      SMS_OFF = 3'h0,
      SMS_ENC_TWO = 3'h1,
      SMS_ENC_ONE = 3'h2,
      SMS_ENC_BOTH = 3'h3,
      SMS_RESET = 3'h4,
      SMS_GATED = 3'h5,
      SMS_TRIGGER = 3'h6,
      SMS_EXTCLK = 3'h7
   } sms_e;
endpackage : tpe_pkg

// file: verilog/timer_pwm_pulse_encoder.sv
/*
 pwm (edge and center aligned), single pulse with fast output, quadrature
 encoder counting and the channel 1 xor feed of a general purpose timer.
 assumes a plain register port with read data one cycle after the strobe,
 and asynchronous channel pins that are synchronised here.
*/
`timescale 1ns/1ps
`include "tpe_consts.svh"
module timer_pwm_pulse_encoder
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   // register port
   input wire tpe_pkg::addr_t addr_in,
   input wire tpe_pkg::word_t wr_data_in,
   input wire logic wr_strobe_in,
   input wire logic rd_strobe_in,
   output tpe_pkg::word_t rd_data_out,
   // channel pins 1..4, bit 0 is pin one
   input wire logic [3:0] chan_pin_in,
   // waveform and state
   output logic compare_reference_signal_out,
   output logic compare_output_pin_out,
   output logic count_direction_bit_out,
   output logic update_event_out
);
   import tpe_pkg::*;

   function automatic logic is_pwm(input ocm_e m);
      is_pwm = (m == OCM_PWM1) || (m == OCM_PWM2);
   endfunction : is_pwm

   function automatic logic is_enc(input sms_e s);
      is_enc = (s == SMS_ENC_TWO) || (s == SMS_ENC_ONE) || (s == SMS_ENC_BOTH);
   endfunction : is_enc

   // ****************************************************
   // state
   // ****************************************************
   logic en_q, en_d, opm_q, opm_d, dir_q, dir_d, xsel_q, xsel_d;
   logic [1:0] cms_q, cms_d;
   sms_e sms_q, sms_d;
   logic tsel_q, tsel_d, pol1_q, pol1_d, pol2_q, pol2_d;
   ocm_e ocm_q, ocm_d;
   logic fe_q, fe_d, opol_q, opol_d;
   cnt_t arr_q, arr_d, ccr_q, ccr_d, cnt_q, cnt_d;
   logic cflag_q, cflag_d, uflag_q, uflag_d, force_q, force_d;
   logic ref_q, ref_d, outp_q, outp_d, uev_q, uev_d;
   word_t rd_q, rd_d;
   logic [3:0] s1_q, s2_q;
   logic f1p_q, f1p_d, f2p_q, f2p_d;
   logic t1, f1, f2, e1, e2, enc, center, trig_edge, upd, match, ndir;
   logic pulse, lvl1, wr_ctrl, wr_cnt;
   cnt_t cmp_cnt;

   // ****************************************************
   // input conditioning
   // ****************************************************
   always_comb
   begin
      // hall sensors on pins two to four feed channel 1
      t1 = xsel_q ? ^s2_q[3:1] : s2_q[0];
      f1 = t1 ^ pol1_q;
      f2 = s2_q[1] ^ pol2_q;
      e1 = f1 != f1p_q;
      e2 = f2 != f2p_q;
      enc = is_enc(sms_q);
      center = cms_q != `CMS_EDGE;
      trig_edge = (sms_q == SMS_TRIGGER) && (tsel_q ? (f2 & ~f2p_q) : (f1 & ~f1p_q));
      wr_ctrl = wr_strobe_in && (addr_in == `A_CTRL);
      wr_cnt = wr_strobe_in && (addr_in == `A_COUNT);
   end

   // ****************************************************
   // next state
   // ****************************************************
   always_comb
   begin
      en_d = en_q;
      opm_d = opm_q;
      dir_d = dir_q;
      xsel_d = xsel_q;
      cms_d = cms_q;
      sms_d = sms_q;
      tsel_d = tsel_q;
      pol1_d = pol1_q;
      pol2_d = pol2_q;
      ocm_d = ocm_q;
      fe_d = fe_q;
      opol_d = opol_q;
      arr_d = arr_q;
      ccr_d = ccr_q;
      cnt_d = cnt_q;
      force_d = force_q;
      f1p_d = f1;
      f2p_d = f2;
      upd = 1'b0;
      ndir = dir_q;
      pulse = 1'b0;
      // counter
      if (enc)
      begin
         // same-cycle change of both inputs is ambiguous: dropped
         if ((e1 || e2) && !(e1 && e2))
         begin
            ndir = e1 ? ~(f1 ^ f2) : (f1 ^ f2);
            dir_d = ndir;
            pulse = (e1 && sms_q[1]) || (e2 && sms_q[0]);
            if (en_q && pulse)
            begin
               if (!ndir)
               begin
                  if (cnt_q == arr_q)
                  begin
                     cnt_d = `CNT_ZERO;
                     upd = 1'b1;
                  end
                  else
                     cnt_d = cnt_q + `CNT_ONE;
               end
               else if (cnt_q == `CNT_ZERO)
               begin
                  cnt_d = arr_q;
                  upd = 1'b1;
               end
               else
                  cnt_d = cnt_q - `CNT_ONE;
            end
         end
      end
      else if (en_q)
      begin
         if (!center)
         begin
            if (!dir_q)
            begin
               if (cnt_q == arr_q)
               begin
                  cnt_d = `CNT_ZERO;
                  upd = 1'b1;
               end
               else
                  cnt_d = cnt_q + `CNT_ONE;
            end
            else if (cnt_q == `CNT_ZERO)
            begin
               cnt_d = arr_q;
               upd = 1'b1;
            end
            else
               cnt_d = cnt_q - `CNT_ONE;
         end
         else if (!dir_q)
         begin
            if (cnt_q >= arr_q)
            begin
               dir_d = 1'b1;
               cnt_d = arr_q - `CNT_ONE;
               upd = 1'b1;
            end
            else
               cnt_d = cnt_q + `CNT_ONE;
         end
         else if (cnt_q == `CNT_ZERO)
         begin
            dir_d = 1'b0;
            cnt_d = `CNT_ONE;
            upd = 1'b1;
         end
         else
            cnt_d = cnt_q - `CNT_ONE;
      end
      // software write of the counter overrides the step
      if (wr_cnt)
      begin
         cnt_d = wr_data_in[15:0];
         upd = 1'b0;
         if (center && !enc)
         begin
            if (wr_data_in[15:0] == `CNT_ZERO)
               dir_d = 1'b0;
            else if (wr_data_in[15:0] == arr_q)
               dir_d = 1'b1;
         end
      end
      // configuration writes
      if (wr_ctrl)
      begin
         en_d = wr_data_in[`F_EN];
         opm_d = wr_data_in[`F_OPM];
         cms_d = wr_data_in[`F_CMS_HI:`F_CMS_LO];
         xsel_d = wr_data_in[`F_XOR];
         // direction is software's only in edge-aligned timer mode
         if (!center && !enc)
            dir_d = wr_data_in[`F_DIR];
      end
      if (wr_strobe_in && (addr_in == `A_SLAVE))
      begin
         sms_d = sms_e'(wr_data_in[`F_SMS_HI:`F_SMS_LO]);
         tsel_d = wr_data_in[`F_TSEL];
         pol1_d = wr_data_in[`F_POL1];
         pol2_d = wr_data_in[`F_POL2];
      end
      if (wr_strobe_in && (addr_in == `A_CHAN))
      begin
         ocm_d = ocm_e'(wr_data_in[`F_OCM_HI:`F_OCM_LO]);
         fe_d = wr_data_in[`F_FE];
         opol_d = wr_data_in[`F_OPOL];
      end
      if (wr_strobe_in && (addr_in == `A_RELOAD))
         arr_d = wr_data_in[15:0];
      if (wr_strobe_in && (addr_in == `A_COMPARE))
         ccr_d = wr_data_in[15:0];
      // trigger start and fast output
      if (trig_edge)
      begin
         en_d = 1'b1;
         if (fe_q && is_pwm(ocm_q))
            force_d = 1'b1;
      end
      if (upd)
      begin
         force_d = 1'b0;
         if (opm_q)
            en_d = 1'b0;
      end
      if (!is_pwm(ocm_q))
         force_d = 1'b0;
   end

   // ****************************************************
   // compare, reference and flags
   // ****************************************************
   always_comb
   begin
      match = en_q && (cnt_q == ccr_q);
      // single pulse drops its level on the wrap, not one count later
      cmp_cnt = (opm_q && upd && !enc) ? cnt_d : cnt_q;
      // down-count pwm1 never reaches zero duty
      if (!center && dir_q)
         lvl1 = (ccr_q > arr_q) || !(cmp_cnt > ccr_q);
      else
         lvl1 = cmp_cnt < ccr_q;
      unique case (ocm_q)
         OCM_FROZEN: ref_d = ref_q;
         OCM_SET: ref_d = match ? 1'b1 : ref_q;
         OCM_CLEAR: ref_d = match ? 1'b0 : ref_q;
         OCM_TOGGLE: ref_d = match ? ~ref_q : ref_q;
         OCM_LOW: ref_d = 1'b0;
         OCM_HIGH: ref_d = 1'b1;
         OCM_PWM1: ref_d = lvl1;
         OCM_PWM2: ref_d = ~lvl1;
      endcase
      // fast output skips the compare latency
      if (force_q)
         ref_d = (ocm_q == OCM_PWM2);
      outp_d = ref_d ^ opol_q;
      uev_d = upd;
      cflag_d = cflag_q;
      uflag_d = uflag_q;
      if (wr_strobe_in && (addr_in == `A_STATUS))
      begin
         cflag_d = cflag_q & ~wr_data_in[`F_CFLAG];
         uflag_d = uflag_q & ~wr_data_in[`F_UFLAG];
      end
      // set beats a clear in the same cycle
      if (match && (!center || (cms_q == `CMS_BOTH) ||
          ((cms_q == `CMS_DOWN) && dir_q) || ((cms_q == `CMS_UP) && !dir_q)))
         cflag_d = 1'b1;
      if (upd)
         uflag_d = 1'b1;
      rd_d = `WORD_ZERO;
      if (rd_strobe_in)
      begin
         unique case (addr_in)
            `A_CTRL:
            begin
               rd_d[`F_EN] = en_q;
               rd_d[`F_OPM] = opm_q;
               rd_d[`F_DIR] = dir_q;
               rd_d[`F_CMS_HI:`F_CMS_LO] = cms_q;
               rd_d[`F_XOR] = xsel_q;
            end
            `A_SLAVE:
            begin
               rd_d[`F_SMS_HI:`F_SMS_LO] = sms_q;
               rd_d[`F_TSEL] = tsel_q;
               rd_d[`F_POL1] = pol1_q;
               rd_d[`F_POL2] = pol2_q;
            end
            `A_CHAN:
            begin
               rd_d[`F_OCM_HI:`F_OCM_LO] = ocm_q;
               rd_d[`F_FE] = fe_q;
               rd_d[`F_OPOL] = opol_q;
            end
            `A_RELOAD: rd_d[15:0] = arr_q;
            `A_COMPARE: rd_d[15:0] = ccr_q;
            `A_COUNT: rd_d[15:0] = cnt_q;
            `A_STATUS:
            begin
               rd_d[`F_CFLAG] = cflag_q;
               rd_d[`F_UFLAG] = uflag_q;
               rd_d[`F_REF] = ref_q;
            end
            default: rd_d = `WORD_ZERO;
         endcase
      end
   end

   // ****************************************************
   // registers
   // ****************************************************
   always_ff @(posedge clk_sys_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         en_q <= 1'b0;
         opm_q <= 1'b0;
         dir_q <= 1'b0;
         xsel_q <= 1'b0;
         cms_q <= `CMS_EDGE;
         sms_q <= SMS_OFF;
         tsel_q <= 1'b0;
         pol1_q <= 1'b0;
         pol2_q <= 1'b0;
         ocm_q <= OCM_FROZEN;
         fe_q <= 1'b0;
         opol_q <= 1'b0;
         arr_q <= `CNT_ZERO;
         ccr_q <= `CNT_ZERO;
         cnt_q <= `CNT_ZERO;
         cflag_q <= 1'b0;
         uflag_q <= 1'b0;
         force_q <= 1'b0;
         ref_q <= 1'b0;
         outp_q <= 1'b0;
         uev_q <= 1'b0;
         rd_q <= `WORD_ZERO;
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         f1p_q <= 1'b0;
         f2p_q <= 1'b0;
      end
      else
      begin
         en_q <= en_d;
         opm_q <= opm_d;
         dir_q <= dir_d;
         xsel_q <= xsel_d;
         cms_q <= cms_d;
         sms_q <= sms_d;
         tsel_q <= tsel_d;
         pol1_q <= pol1_d;
         pol2_q <= pol2_d;
         ocm_q <= ocm_d;
         fe_q <= fe_d;
         opol_q <= opol_d;
         arr_q <= arr_d;
         ccr_q <= ccr_d;
         cnt_q <= cnt_d;
         cflag_q <= cflag_d;
         uflag_q <= uflag_d;
         force_q <= force_d;
         ref_q <= ref_d;
         outp_q <= outp_d;
         uev_q <= uev_d;
         rd_q <= rd_d;
         s1_q <= chan_pin_in;
         s2_q <= s1_q;
         f1p_q <= f1p_d;
         f2p_q <= f2p_d;
      end
   end

   assign rd_data_out = rd_q;
   assign compare_reference_signal_out = ref_q;
   assign compare_output_pin_out = outp_q;
   assign count_direction_bit_out = dir_q;
   assign update_event_out = uev_q;

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);

   a_pwm1_down_low: assert property (
      (ocm_q == OCM_PWM1) && !center && dir_q && !force_q && (cnt_q > ccr_q)
      && (ccr_q <= arr_q) |=> !ref_q)
      else $error("pwm1 down reference not low");
   a_down_full_duty: assert property (
      (ocm_q == OCM_PWM1) && !center && dir_q && !force_q && (ccr_q > arr_q)
      |=> ref_q)
      else $error("reference not held high");
   a_pwm_up_level: assert property (
      (ocm_q == OCM_PWM2) && !dir_q && !force_q && (cnt_q < ccr_q) |=> !ref_q)
      else $error("pwm2 up reference not low");
   a_pulse_stop: assert property (
      opm_q && upd |=> !en_q)
      else $error("single pulse did not stop");
   a_trig_start: assert property (
      trig_edge && !upd |=> en_q)
      else $error("trigger did not start counter");
   a_fast_force: assert property (
      trig_edge && fe_q && (ocm_q == OCM_PWM2) && !upd && !wr_strobe_in
      |=> force_q ##1 ref_q)
      else $error("fast output not forced");
   a_fast_pwm_only: assert property (
      !is_pwm(ocm_q) |=> !force_q)
      else $error("fast output outside pwm");
   a_enc_dir: assert property (
      enc && e1 && !e2 |=> dir_q == ~($past(f1) ^ $past(f2)))
      else $error("encoder direction wrong");
   a_enc_both: assert property (
      enc && e1 && e2 && !wr_cnt |=> $stable(dir_q) && $stable(cnt_q))
      else $error("double edge changed counter");
   a_cnt_wr_noupd: assert property (
      wr_cnt |=> !uev_q)
      else $error("counter write gave update");

   c_enc_count: cover property (enc && en_q ##1 $changed(cnt_q));
   c_center_turn: cover property (center && en_q && upd && dir_d);
   c_pulse_done: cover property (opm_q && en_q ##[1:50] !en_q);
   c_fast_out: cover property (force_q && ref_q);
endmodule : timer_pwm_pulse_encoder

// file: testbench/quad_sensor_model.sv
/*
 encoder, hall and trigger lines into the timer's channel pins.
 assumes the bench clock; pins change only just after a rising edge.
*/
`timescale 1ns/1ps
module quad_sensor_model
(
   // clock
   input wire logic clk_sys_in,
   // channel pins, bit 0 is pin one
   output logic [3:0] pins_out
);
   logic [1:0] pos_q;
   initial
   begin
      pins_out = 4'h0;
      pos_q = 2'h0;
   end
   // each level held four cycles so both sync flops see it
   task automatic put(input logic [3:0] v);
      @(posedge clk_sys_in);
      pins_out <= v;
      repeat (4) @(posedge clk_sys_in);
   endtask : put
   // one quadrature step, pin one leads when fwd is set
   task automatic step(input logic fwd);
      logic [1:0] gray;
      pos_q = fwd ? pos_q + 2'h1 : pos_q - 2'h1;
      gray = pos_q ^ (pos_q >> 1);
      put({pins_out[3:2], gray});
   endtask : step
endmodule : quad_sensor_model

// file: testbench/test_timer_pwm_pulse_encoder.sv
/*
 self-checking bench of the pwm / single pulse / encoder timer.
 assumes tpe_consts.svh offsets and quad_sensor_model on the pins.
*/
`timescale 1ns/1ps
`include "tpe_consts.svh"
module test_timer_pwm_pulse_encoder;
   import tpe_pkg::*;
   logic clk_sys_in, rst_b_in, wr_strobe_in, rd_strobe_in;
   addr_t addr_in;
   word_t wr_data_in, rd_data_out, v;
   logic [3:0] chan_pin_in;
   logic ref_w, out_w, dir_w, upd_w;
   int fail_count, n_compared, seed, k, n;
   word_t hi, exp_w;
   word_t tch[5] = '{32'h08, 32'h0f, 32'h07, 32'h0e, 32'h06};
   word_t texp[5] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h1};
   timer_pwm_pulse_encoder dut_u
   (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .addr_in(addr_in),
      .wr_data_in(wr_data_in),
      .wr_strobe_in(wr_strobe_in),
      .rd_strobe_in(rd_strobe_in),
      .rd_data_out(rd_data_out),
      .chan_pin_in(chan_pin_in),
      .compare_reference_signal_out(ref_w),
      .compare_output_pin_out(out_w),
      .count_direction_bit_out(dir_w),
      .update_event_out(upd_w)
   );
   quad_sensor_model sensor_u
   (
      .clk_sys_in(clk_sys_in),
      .pins_out(chan_pin_in)
   );
   // ****************************************************
   // helpers
   // ****************************************************
   task automatic complete_run();
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   task automatic check(input word_t seen, input word_t exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input addr_t a, input word_t d);
      @(posedge clk_sys_in);
      wr_strobe_in <= 1'b1;
      addr_in <= a;
      wr_data_in <= d;
      @(posedge clk_sys_in);
      wr_strobe_in <= 1'b0;
   endtask : wr
   task automatic rd(input addr_t a, output word_t d);
      @(posedge clk_sys_in);
      rd_strobe_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_sys_in);
      rd_strobe_in <= 1'b0;
      #1;
      d = rd_data_out;
   endtask : rd
   task automatic do_reset();
      @(posedge clk_sys_in);
      rst_b_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      @(posedge clk_sys_in);
   endtask : do_reset
   // cycles from the last update pulse to the next one
   task automatic wait_upd(output int p);
      p = 1;
      @(negedge clk_sys_in);
      while (upd_w !== 1'b1 && p < 200)
      begin
         @(negedge clk_sys_in);
         p++;
      end
   endtask : wait_upd
   // reload 9: 40 cycles are four whole periods, so phase does not matter
   task automatic duty(input word_t ctl, input word_t ch, input word_t cmp, input int e);
      word_t ho;
      hi = 0;
      ho = 0;
      wr(`A_CTRL, 32'h0);
      wr(`A_RELOAD, 32'h9);
      wr(`A_COMPARE, cmp);
      wr(`A_CHAN, ch);
      wr(`A_COUNT, 32'h0);
      wr(`A_CTRL, ctl);
      repeat (20) @(negedge clk_sys_in);
      repeat (40)
      begin
         @(negedge clk_sys_in);
         hi += ref_w;
         ho += out_w;
      end
      check(hi, e);
      check(ho, ch[4] ? 40 - e : e);
   endtask : duty
   task automatic arm(input word_t ch, input word_t ctl, input word_t sl);
      sensor_u.put(4'h0);
      wr(`A_CTRL, 32'h0);
      wr(`A_COUNT, 32'h0);
      wr(`A_RELOAD, 32'h14);
      wr(`A_COMPARE, 32'h8);
      wr(`A_CHAN, ch);
      wr(`A_SLAVE, sl);
      wr(`A_CTRL, ctl);
   endtask : arm
   function automatic word_t enc_steps(input int sms);
      return (sms == 3) ? 32'h4 : 32'h2;
   endfunction : enc_steps
   // one encoder count with wrap between zero and reload
   function automatic word_t wrap_step(input word_t c, input logic fwd, input word_t top);
      if (fwd)
         return (c == top) ? 32'h0 : c + 32'h1;
      return (c == 32'h0) ? top : c - 32'h1;
   endfunction : wrap_step
   // ****************************************************
   // clock, watchdog and main sequence
   // ****************************************************
   initial
   begin
      clk_sys_in = 1'b0;
      forever #2 clk_sys_in = ~clk_sys_in;
   end
   initial
   begin
      repeat (30000) @(posedge clk_sys_in);
      fail_count++;
      complete_run();
   end
   initial
   begin
      rst_b_in = 1'b0;
      wr_strobe_in = 1'b0;
      rd_strobe_in = 1'b0;
      addr_in = 8'h00;
      wr_data_in = 32'h0;
      fail_count = 0;
      n_compared = 0;
      seed = 94;
      do_reset();
      rd(`A_RELOAD, v);
      check(v, 32'h0);
      wr(8'h1c, 32'h5a5a_5a5a);
      rd(8'h1c, v);
      check(v, 32'h0);
      v = $random(seed);
      wr(`A_RELOAD, v | 32'hffff_0000);
      rd(`A_RELOAD, v);
      check(v[31:16], 32'h0);
      for (k = 0; k < 4; k++)
      begin
         v = 1 + ($unsigned($random(seed)) % 9);
         n = $random(seed) & 1;
         duty(32'h1, (n << 4) | 32'h6, v, 4 * v);
         duty(32'h1, (n << 4) | 32'h7, v, 4 * (10 - v));
         duty(32'h5, (n << 4) | 32'h6, v, 4 * (v + 1));
      end
      duty(32'h5, 32'h6, 32'hc, 40);
      wr(`A_CTRL, 32'h0);
      // encoder modes, forward then back
      for (k = 1; k <= 3; k++)
      begin
         wr(`A_CTRL, 32'h0);
         wr(`A_RELOAD, 32'h64);
         wr(`A_SLAVE, k);
         wr(`A_COUNT, 32'h32);
         wr(`A_CTRL, 32'h1);
         repeat (4) sensor_u.step(1'b1);
         rd(`A_COUNT, v);
         check(v, 32'h32 + enc_steps(k));
         check({31'h0, dir_w}, 32'h0);
         repeat (4) sensor_u.step(1'b0);
         rd(`A_COUNT, v);
         check(v, 32'h32);
         check({31'h0, dir_w}, 32'h1);
      end
      // input two moves while only input one counts
      wr(`A_SLAVE, 32'h2);
      sensor_u.step(1'b1);
      sensor_u.step(1'b1);
      sensor_u.step(1'b0);
      rd(`A_COUNT, v);
      check(v, 32'h33);
      check({31'h0, dir_w}, 32'h1);
      sensor_u.step(1'b0);
      wr(`A_SLAVE, 32'h3);
      wr(`A_COUNT, 32'h0);
      sensor_u.step(1'b0);
      rd(`A_COUNT, v);
      check(v, 32'h64);
      sensor_u.put(4'h1);
      sensor_u.put(4'h2);
      rd(`A_COUNT, v);
      check(v, 32'h64);
      check({31'h0, dir_w}, 32'h1);
      sensor_u.step(1'b1);
      rd(`A_COUNT, v);
      check(v, 32'h0);
      // random walk, both inputs counting
      exp_w = 32'h0;
      for (k = 0; k < 24; k++)
      begin
         n = $random(seed) & 1;
         sensor_u.step(n[0]);
         exp_w = wrap_step(exp_w, n[0], 32'h64);
      end
      rd(`A_COUNT, v);
      check(v, exp_w);
      check({31'h0, dir_w}, {31'h0, ~n[0]});
      wr(`A_SLAVE, 32'h0);
      // trigger start, fast output, single pulse
      do_reset();
      for (k = 0; k < 5; k++)
      begin
         // odd runs trigger from input two
         arm(tch[k], 32'h2, 32'h6 | ((k & 1) << 3));
         sensor_u.put((k & 1) ? 4'h2 : 4'h1);
         repeat (2) @(negedge clk_sys_in);
         check({31'h0, ref_w}, texp[k]);
         hi = 0;
         repeat (60)
         begin
            @(negedge clk_sys_in);
            hi += ref_w;
         end
         if (tch[k] == 32'h07)
            check(hi, 32'h14 - 32'h8);
         rd(`A_CTRL, v);
         check(v & 32'h1, 32'h0);
      end
      // pin three alone starts the counter only through the xor feed
      for (k = 0; k < 2; k++)
      begin
         arm(32'h0, k ? 32'h22 : 32'h02, 32'h6);
         sensor_u.put(4'h4);
         rd(`A_CTRL, v);
         check(v & 32'h1, k);
      end
      sensor_u.put(4'h0);
      // update spacing; reset between runs so direction and centre bits never move together
      for (k = 0; k < 4; k++)
      begin
         do_reset();
         wr(`A_RELOAD, 32'ha);
         wr(`A_CTRL, 32'h1 | (k << 3));
         wait_upd(n);
         wait_upd(n);
         check(n, k ? 32'ha : 32'hb);
      end
      wr(`A_COUNT, 32'ha);
      repeat (2) @(negedge clk_sys_in);
      check({31'h0, dir_w}, 32'h1);
      wr(`A_COUNT, 32'h0);
      hi = 0;
      repeat (3)
      begin
         @(negedge clk_sys_in);
         hi += upd_w;
      end
      check({31'h0, dir_w}, 32'h0);
      check(hi, 32'h0);
      // compare flag per centre select; second clear meets the top turn
      for (k = 1; k < 4; k++)
      begin
         do_reset();
         wr(`A_RELOAD, 32'ha);
         wr(`A_COMPARE, 32'h5);
         wr(`A_CTRL, 32'h1 | (k << 3));
         wr(`A_STATUS, 32'h3);
         repeat (5) @(posedge clk_sys_in);
         rd(`A_STATUS, v);
         check(v & 32'h3, (k >> 1) & 1);
         wr(`A_STATUS, 32'h3);
         repeat (5) @(posedge clk_sys_in);
         rd(`A_STATUS, v);
         check(v & 32'h3, 32'h2 | (k & 1));
      end
      complete_run();
   end
endmodule : test_timer_pwm_pulse_encoder
